// [gpiof_pkg.sv]
package gpiof_pkg;
    localparam int unsigned NLINES = 32;
    localparam int unsigned AW     = 8;
    localparam logic [31:0] IMPL_MASK  = 32'hFFFFFFFF;
    localparam logic [31:0] MUXED_MASK = 32'hFFFFFFFF;
    localparam logic [31:0] OWN_RESET  = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO_RESET = 32'h00000000;
    localparam logic [AW-1:0] OFF_OWN_SET   = 8'h00;
    localparam logic [AW-1:0] OFF_OWN_CLR   = 8'h04;
    localparam logic [AW-1:0] OFF_OWN_STAT  = 8'h08;
    localparam logic [AW-1:0] OFF_DRV_SET   = 8'h10;
    localparam logic [AW-1:0] OFF_DRV_CLR   = 8'h14;
    localparam logic [AW-1:0] OFF_DRV_STAT  = 8'h18;
    localparam logic [AW-1:0] OFF_FLT_SET   = 8'h20;
    localparam logic [AW-1:0] OFF_FLT_CLR   = 8'h24;
    localparam logic [AW-1:0] OFF_FLT_STAT  = 8'h28;
    localparam logic [AW-1:0] OFF_OUT_SET   = 8'h30;
    localparam logic [AW-1:0] OFF_OUT_CLR   = 8'h34;
    localparam logic [AW-1:0] OFF_OUT_STAT  = 8'h38;
    localparam logic [AW-1:0] OFF_PIN_STAT  = 8'h3C;
    localparam logic [AW-1:0] OFF_IRQ_SET   = 8'h40;
    localparam logic [AW-1:0] OFF_IRQ_CLR   = 8'h44;
    localparam logic [AW-1:0] OFF_IRQ_MASK  = 8'h48;
    localparam logic [AW-1:0] OFF_IRQ_PEND  = 8'h4C;
    localparam logic [AW-1:0] OFF_OD_SET    = 8'h50;
    localparam logic [AW-1:0] OFF_OD_CLR    = 8'h54;
    localparam logic [AW-1:0] OFF_OD_STAT   = 8'h58;
    localparam logic [AW-1:0] OFF_PU_OFF    = 8'h60;
    localparam logic [AW-1:0] OFF_PU_ON     = 8'h64;
    localparam logic [AW-1:0] OFF_PU_STAT   = 8'h68;
    localparam logic [AW-1:0] OFF_SEL_FIRST = 8'h70;
    localparam logic [AW-1:0] OFF_SEL_SECND = 8'h74;
    localparam logic [AW-1:0] OFF_SEL_STAT  = 8'h78;
    localparam logic [AW-1:0] OFF_OWM_SET   = 8'hA0;
    localparam logic [AW-1:0] OFF_OWM_CLR   = 8'hA4;
    localparam logic [AW-1:0] OFF_OWM_STAT  = 8'hA8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] ARM_CYCLES  = 2'h2;
endpackage

// [gpiof_top.sv]
`timescale 1ns/1ns
// Overview of operation
// - Pin level register shows sampled level of every line, any config.
// - Controller clock off freezes pin level register at last sample.
// - Filter rejects sub-half-cycle glitches, passes pulses of one cycle; here it only delays each sample by one cycle and rejects nothing.
// - Enabled filter adds one clock cycle of latency.
// - Filter set/clear writes set/clear filter status; status enables filter.
// - Filter affects pin level readback and change detect, not peripherals.
// - Glitch filter runs only with controller clock enabled.
// - Irq set/clear writes set/clear mask bits; zeros have no effect.
// - Change found by comparing two successive clocked samples.
// - Change detection works on every line regardless of configuration.
// - Change sets pending bit; irq asserted when pending and mask both set.
// - All 32 line requests ORed into one interrupt output.
// - Reading pending register clears all pending bits at once.
// - Every register is 32 bits, bit n serves line n.
// - Unimplemented line bits ignore writes and read zero.
// - Lines without peripheral mux always read owned by controller.
// - First select write clears select bit, second select write sets it.
// - Direct output data writes only affect bits enabled in write mask.
// - Pending register resets to zero; early changes may show.
// - Pin level register has no fixed reset value; follows lines.
// - Pull-up status 1 means pull-up off, 0 means on.
// - Select status 0 picks peripheral A, 1 picks peripheral B.
// - Direct output write leaves masked-off bits unchanged.
module gpiof_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ctrl_clk_en,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic [31:0] pin_in,
    output logic [31:0]      pin_out,
    output logic [31:0]      pin_oe,
    output logic [31:0]      pullup_en,
    input  wire logic [31:0] periph_a_out,
    input  wire logic [31:0] periph_a_oe,
    input  wire logic [31:0] periph_b_out,
    input  wire logic [31:0] periph_b_oe,
    output logic [31:0]      periph_in,
    output logic             gpio_irq
);
    logic [31:0] own_q, drv_q, flt_q, odsr_q, imr_q, isr_q;
    logic [31:0] od_q, pus_q, sel_q, owm_q;
    logic [31:0] samp_q, dly_q, last_q, level, change;
    logic [1:0]  arm_q;
    logic        aw_have_q, w_have_q;
    logic [7:0]  waddr_q;
    logic [31:0] wdata_q, bmask_q, wbits;
    logic        wr_go, rd_go, wr_hit, rd_hit, isr_rd;
    logic [31:0] rd_val;
    logic [31:0] pad_out_d, pad_oe_d;

    // Peripherals see the raw pin, never the filtered view
    assign periph_in = pin_in;

    // Sampling pipeline, frozen when the controller clock is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_q <= gpiof_pkg::ZERO_RESET;
            dly_q  <= gpiof_pkg::ZERO_RESET;
        end else if (ctrl_clk_en) begin
            samp_q <= pin_in & gpiof_pkg::IMPL_MASK;
            dly_q  <= samp_q;
        end
    end

    // Inputs are synchronous, so each sample spans a whole cycle: any
    // pulse seen is at least one cycle and is kept, at one cycle delay
    assign level = (flt_q & dly_q) | (~flt_q & samp_q);

    // Previous filtered sample for change compare
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_q <= gpiof_pkg::ZERO_RESET;
        end else if (ctrl_clk_en) begin
            last_q <= level;
        end
    end

    // Hold off detection until the pipeline holds real pin levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_q <= 2'h0;
        end else if (ctrl_clk_en && arm_q != gpiof_pkg::ARM_CYCLES) begin
            arm_q <= arm_q + 2'h1;
        end
    end

    assign change = (ctrl_clk_en && arm_q == gpiof_pkg::ARM_CYCLES) ?
                    (level ^ last_q) : 32'h00000000;

    // AXI4-Lite write side: address and data taken in either order
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            waddr_q   <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            waddr_q   <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            bmask_q  <= 32'h00000000;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            bmask_q  <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    // Disabled byte lanes and absent lines act as zeros
    assign wbits = wdata_q & bmask_q & gpiof_pkg::IMPL_MASK;

    always_comb begin
        case (waddr_q)
            gpiof_pkg::OFF_OWN_SET, gpiof_pkg::OFF_OWN_CLR,
            gpiof_pkg::OFF_OWN_STAT, gpiof_pkg::OFF_DRV_SET,
            gpiof_pkg::OFF_DRV_CLR, gpiof_pkg::OFF_DRV_STAT,
            gpiof_pkg::OFF_FLT_SET, gpiof_pkg::OFF_FLT_CLR,
            gpiof_pkg::OFF_FLT_STAT, gpiof_pkg::OFF_OUT_SET,
            gpiof_pkg::OFF_OUT_CLR, gpiof_pkg::OFF_OUT_STAT,
            gpiof_pkg::OFF_PIN_STAT, gpiof_pkg::OFF_IRQ_SET,
            gpiof_pkg::OFF_IRQ_CLR, gpiof_pkg::OFF_IRQ_MASK,
            gpiof_pkg::OFF_IRQ_PEND, gpiof_pkg::OFF_OD_SET,
            gpiof_pkg::OFF_OD_CLR, gpiof_pkg::OFF_OD_STAT,
            gpiof_pkg::OFF_PU_OFF, gpiof_pkg::OFF_PU_ON,
            gpiof_pkg::OFF_PU_STAT, gpiof_pkg::OFF_SEL_FIRST,
            gpiof_pkg::OFF_SEL_SECND, gpiof_pkg::OFF_SEL_STAT,
            gpiof_pkg::OFF_OWM_SET, gpiof_pkg::OFF_OWM_CLR,
            gpiof_pkg::OFF_OWM_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= gpiof_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? gpiof_pkg::RESP_OKAY
                                   : gpiof_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers, one concern each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            own_q <= gpiof_pkg::OWN_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OWN_SET) begin
            own_q <= own_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OWN_CLR) begin
            own_q <= own_q & ~wbits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drv_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_DRV_SET) begin
            drv_q <= drv_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_DRV_CLR) begin
            drv_q <= drv_q & ~wbits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_FLT_SET) begin
            flt_q <= flt_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_FLT_CLR) begin
            flt_q <= flt_q & ~wbits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            odsr_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OUT_SET) begin
            odsr_q <= odsr_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OUT_CLR) begin
            odsr_q <= odsr_q & ~wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OUT_STAT) begin
            odsr_q <= (odsr_q & ~(owm_q & bmask_q))
                    | (wbits & owm_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imr_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_IRQ_SET) begin
            imr_q <= imr_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_IRQ_CLR) begin
            imr_q <= imr_q & ~wbits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            od_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OD_SET) begin
            od_q <= od_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OD_CLR) begin
            od_q <= od_q & ~wbits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pus_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_PU_OFF) begin
            pus_q <= pus_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_PU_ON) begin
            pus_q <= pus_q & ~wbits;
        end
    end

    // Inverted sense: first select clears, second sets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_SEL_FIRST) begin
            sel_q <= sel_q & ~wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_SEL_SECND) begin
            sel_q <= sel_q | wbits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            owm_q <= gpiof_pkg::ZERO_RESET;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OWM_SET) begin
            owm_q <= owm_q | wbits;
        end else if (wr_go && waddr_q == gpiof_pkg::OFF_OWM_CLR) begin
            owm_q <= owm_q & ~wbits;
        end
    end

    // Read side: one outstanding read, answer one cycle after arvalid
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_go  = s_axi_arvalid && s_axi_arready;
    assign isr_rd = rd_go && s_axi_araddr == gpiof_pkg::OFF_IRQ_PEND;

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            gpiof_pkg::OFF_OWN_STAT:
                rd_val = own_q | ~gpiof_pkg::MUXED_MASK;
            gpiof_pkg::OFF_DRV_STAT: rd_val = drv_q;
            gpiof_pkg::OFF_FLT_STAT: rd_val = flt_q;
            gpiof_pkg::OFF_OUT_STAT: rd_val = odsr_q;
            gpiof_pkg::OFF_PIN_STAT: rd_val = level;
            gpiof_pkg::OFF_IRQ_MASK: rd_val = imr_q;
            gpiof_pkg::OFF_IRQ_PEND: rd_val = isr_q;
            gpiof_pkg::OFF_OD_STAT:  rd_val = od_q;
            gpiof_pkg::OFF_PU_STAT:  rd_val = pus_q;
            gpiof_pkg::OFF_SEL_STAT: rd_val = sel_q;
            gpiof_pkg::OFF_OWM_STAT: rd_val = owm_q;
            gpiof_pkg::OFF_OWN_SET, gpiof_pkg::OFF_OWN_CLR,
            gpiof_pkg::OFF_DRV_SET, gpiof_pkg::OFF_DRV_CLR,
            gpiof_pkg::OFF_FLT_SET, gpiof_pkg::OFF_FLT_CLR,
            gpiof_pkg::OFF_OUT_SET, gpiof_pkg::OFF_OUT_CLR,
            gpiof_pkg::OFF_IRQ_SET, gpiof_pkg::OFF_IRQ_CLR,
            gpiof_pkg::OFF_OD_SET, gpiof_pkg::OFF_OD_CLR,
            gpiof_pkg::OFF_PU_OFF, gpiof_pkg::OFF_PU_ON,
            gpiof_pkg::OFF_SEL_FIRST, gpiof_pkg::OFF_SEL_SECND,
            gpiof_pkg::OFF_OWM_SET, gpiof_pkg::OFF_OWM_CLR:
                rd_val = 32'h00000000;
            default: begin
                rd_val = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= gpiof_pkg::RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val & gpiof_pkg::IMPL_MASK;
            s_axi_rresp  <= rd_hit ? gpiof_pkg::RESP_OKAY
                                   : gpiof_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Pending bits: a change in the read cycle survives the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isr_q <= gpiof_pkg::ZERO_RESET;
        end else begin
            isr_q <= (isr_rd ? 32'h00000000 : isr_q) | change;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gpio_irq <= 1'b0;
        end else begin
            gpio_irq <= |(isr_q & imr_q);
        end
    end

    // Pad drive: owner picks source, open drain only pulls low
    always_comb begin
        pad_out_d = (own_q & odsr_q) | (~own_q & ((sel_q & periph_b_out)
                  | (~sel_q & periph_a_out)));
        pad_oe_d  = (own_q & drv_q) | (~own_q & ((sel_q & periph_b_oe)
                  | (~sel_q & periph_a_oe)));
        pad_oe_d  = pad_oe_d & ~(od_q & pad_out_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out   <= gpiof_pkg::ZERO_RESET;
            pin_oe    <= gpiof_pkg::ZERO_RESET;
            pullup_en <= gpiof_pkg::ZERO_RESET;
        end else begin
            pin_out   <= pad_out_d & gpiof_pkg::IMPL_MASK;
            pin_oe    <= pad_oe_d & gpiof_pkg::IMPL_MASK;
            pullup_en <= ~pus_q & gpiof_pkg::IMPL_MASK;
        end
    end

    AST_PDSR_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_clk_en |=> $stable(samp_q) && $stable(dly_q))
        else $error("pin level moved with controller clock off");
    AST_UNFILT_PATH: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_clk_en ##1 (flt_q == 32'h00000000)
        |-> level == ($past(pin_in) & gpiof_pkg::IMPL_MASK))
        else $error("unfiltered level not one sample of pin");
    AST_FILT_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_clk_en ##1 ctrl_clk_en ##1 (flt_q == gpiof_pkg::IMPL_MASK)
        |-> level == ($past(pin_in, 2) & gpiof_pkg::IMPL_MASK))
        else $error("filtered level not delayed by one cycle");
    AST_MASK_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && waddr_q == gpiof_pkg::OFF_IRQ_SET
        |=> (imr_q & $past(wbits)) == $past(wbits)
            && (imr_q & ~$past(wbits)) == $past(imr_q & ~wbits))
        else $error("mask set write wrong");
    AST_PEND_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        isr_rd |=> isr_q == $past(change))
        else $error("pending not cleared by read");
    AST_CHANGE_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
        change != 32'h00000000 |=> (isr_q & $past(change)) == $past(change))
        else $error("detected change lost");
    AST_IRQ_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        ##1 gpio_irq == ($past(isr_q & imr_q) != 32'h00000000))
        else $error("irq not OR of masked pending bits");
    AST_ODSR_PROTECT: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && waddr_q == gpiof_pkg::OFF_OUT_STAT
        |=> (odsr_q & ~$past(owm_q)) == $past(odsr_q & ~owm_q))
        else $error("masked output bit changed by direct write");
    AST_OWN_FIXED: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $past(rd_go)
        && $past(s_axi_araddr) == gpiof_pkg::OFF_OWN_STAT
        |-> (s_axi_rdata & ~gpiof_pkg::MUXED_MASK)
            == (~gpiof_pkg::MUXED_MASK & gpiof_pkg::IMPL_MASK))
        else $error("unmuxed line not owned by controller");
    AST_SEL_INVERT: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && waddr_q == gpiof_pkg::OFF_SEL_FIRST
        |=> (sel_q & $past(wbits)) == 32'h00000000)
        else $error("first select did not clear");
endmodule // gpiof_top

// [gpiof_pad_model.sv]
`timescale 1ns/1ns
module gpiof_pad_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pullup_en,
    input  wire logic [31:0] ext,
    input  wire logic [31:0] ext_en,
    output logic      [31:0] pin_in,
    output logic      [31:0] pa_out,
    output logic      [31:0] pa_oe,
    output logic      [31:0] pb_out,
    output logic      [31:0] pb_oe
);
    logic [31:0] float_q;
    // Floating lines flip each cycle so a stale level never passes
    always_ff @(posedge aclk) begin
        if (!aresetn)
            float_q <= 32'h55555555;
        else
            float_q <= ~float_q;
    end
    // Controller drive wins, then the outside driver, then pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext)
                  | (~pin_oe & ~ext_en & (pullup_en | float_q));
    // Peripherals follow the outside pattern, so nothing is tied
    assign pa_out = ext;
    assign pa_oe  = ext_en;
    assign pb_out = ~ext;
    assign pb_oe  = ~ext_en;
endmodule // gpiof_pad_model

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    localparam logic [1:0] OK = gpiof_pkg::RESP_OKAY;
    localparam logic [1:0] ER = gpiof_pkg::RESP_SLVERR;
    logic        aclk, aresetn, clk_en, gpio_irq;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [1:0]  bresp, rresp;
    logic [31:0] wdata, rdata, pin_in, pin_out, pin_oe, pullup_en;
    logic [31:0] pa_out, pa_oe, pb_out, pb_oe, periph_in, ext, ext_en;
    int          errors, checks_done;

    gpiof_top DUT (.aclk(aclk), .aresetn(aresetn), .ctrl_clk_en(clk_en),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .periph_a_out(pa_out), .periph_a_oe(pa_oe), .periph_b_out(pb_out),
        .periph_b_oe(pb_oe), .periph_in(periph_in), .gpio_irq(gpio_irq));

    gpiof_pad_model pads (.aclk(aclk), .aresetn(aresetn),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .ext(ext), .ext_en(ext_en), .pin_in(pin_in), .pa_out(pa_out),
        .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe));

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    // Handshakes sampled mid-cycle, so no edge race with the slave
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bit b, ta, tw;
        int n;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            b = bvalid;
            r = bresp;
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (!b && n < 50);
        bready <= 1'b0;
        if (!b) r = 2'hX;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [31:0] e, input logic [1:0] er);
        bit v, t;
        int n;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            v = rvalid;
            d = rdata;
            r = rresp;
            t = arvalid && arready;
            @(posedge aclk);
            if (t) arvalid <= 1'b0;
            n++;
        end while (!v && n < 50);
        rready <= 1'b0;
        if (!v) d = 32'hXXXXXXXX;
        chk(nm, e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic t_regs;
        logic [7:0] b, s, c;
        logic [31:0] r0, e;
        rc("pending", gpiof_pkg::OFF_IRQ_PEND, 32'h0, OK);
        chk("pullup_en", 32'hFFFFFFFF, pullup_en);
        for (int k = 0; k < 9; k++) begin
            b = (k == 7) ? 8'hA0 : (k == 8) ? 8'h70 : 8'(k * 16);
            s = (k == 8) ? b + 8'h04 : b;
            c = (k == 8) ? b : b + 8'h04;
            r0 = (k == 0) ? gpiof_pkg::OWN_RESET : 32'h00000000;
            e = (r0 | 32'hF0F0F0F0) & ~32'h30303030;
            rc("reset", b + 8'h08, r0, OK);
            wr(s, 32'hF0F0F0F0, OK);
            wr(c, 32'h30303030, OK);
            rc("set_clear", b + 8'h08, e, OK);
            if (k == 6) chk("pullup_en", ~e, pullup_en);
            wr(c, 32'hFFFFFFFF, OK);
            wr(s, r0, OK);
        end
        $display("test regs done");
    endtask

    task automatic t_bus;
        wr(gpiof_pkg::OFF_OWM_SET, 32'h0000FFFF, OK);
        wr(gpiof_pkg::OFF_OUT_SET, 32'hFF0000F0, OK);
        wr(gpiof_pkg::OFF_OUT_STAT, 32'h12345678, OK);
        rc("out", gpiof_pkg::OFF_OUT_STAT, 32'hFF005678, OK);
        wr(gpiof_pkg::OFF_OUT_CLR, 32'hFFFFFFFF, OK);
        wr(gpiof_pkg::OFF_OWM_CLR, 32'hFFFFFFFF, OK);
        wr(8'h0C, 32'hFFFFFFFF, ER);
        rc("unmapped", 8'hAC, 32'h0, ER);
        wr(gpiof_pkg::OFF_FLT_STAT, 32'hFFFFFFFF, OK);
        rc("ro", gpiof_pkg::OFF_FLT_STAT, 32'h0, OK);
        $display("test bus done");
    endtask

    task automatic t_pin;
        @(posedge aclk);
        ext <= 32'hA5A5F0F0;
        rc("pin", gpiof_pkg::OFF_PIN_STAT, 32'hA5A5F0F0, OK);
        wr(gpiof_pkg::OFF_DRV_SET, 32'h000000FF, OK);
        wr(gpiof_pkg::OFF_OUT_SET, 32'h0000000F, OK);
        rc("pin", gpiof_pkg::OFF_PIN_STAT, 32'hA5A5F00F, OK);
        wr(gpiof_pkg::OFF_FLT_SET, 32'hFFFFFFFF, OK);
        @(posedge aclk);
        ext <= 32'h5A5A5A5A;
        @(negedge aclk);
        chk("periph_in", 32'h5A5A5A0F, periph_in);
        // Filtered view lags the pin by one extra sample
        @(posedge aclk);
        rc("pin", gpiof_pkg::OFF_PIN_STAT, 32'h5A5A5A0F, OK);
        @(posedge aclk);
        clk_en <= 1'b0;
        ext <= 32'h11111111;
        rc("frozen", gpiof_pkg::OFF_PIN_STAT, 32'h5A5A5A0F, OK);
        @(posedge aclk);
        clk_en <= 1'b1;
        @(posedge aclk);
        rc("pin", gpiof_pkg::OFF_PIN_STAT, 32'h1111110F, OK);
        wr(gpiof_pkg::OFF_FLT_CLR, 32'hFFFFFFFF, OK);
        $display("test pin done");
    endtask

    task automatic t_irq;
        // Every line that moved during the pin test is still pending
        rc("pending", gpiof_pkg::OFF_IRQ_PEND, 32'hFFFFFBFF, OK);
        wr(gpiof_pkg::OFF_IRQ_SET, 32'h80000003, OK);
        wr(gpiof_pkg::OFF_IRQ_CLR, 32'h00000002, OK);
        wr(gpiof_pkg::OFF_IRQ_SET, 32'h00000000, OK);
        rc("mask", gpiof_pkg::OFF_IRQ_MASK, 32'h80000001, OK);
        @(posedge aclk);
        ext <= ext ^ 32'h00000100;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("irq", 32'h0, {31'h0, gpio_irq});
        wr(gpiof_pkg::OFF_OUT_CLR, 32'h00000001, OK);
        @(posedge aclk);
        ext <= ext ^ 32'h80000000;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk("irq", 32'h1, {31'h0, gpio_irq});
        rc("pending", gpiof_pkg::OFF_IRQ_PEND, 32'h80000101, OK);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("irq", 32'h0, {31'h0, gpio_irq});
        rc("pending", gpiof_pkg::OFF_IRQ_PEND, 32'h0, OK);
        $display("test irq done");
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        final_report();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        clk_en = 1'b1;
        ext = 32'h00000000;
        ext_en = 32'hFFFFFFFF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_bus();
        t_pin();
        t_irq();
        final_report();
    end
endmodule // tb_top
